// File: asrc_pkg.sv
package asrc_pkg;
    // ****************************************************************
    // Widths of the memory port
    // ****************************************************************
    localparam int ASRC_AW = 18;
    localparam int ASRC_DW = 16;
    localparam int ASRC_BW = 8;

    // ****************************************************************
    // Timing (ns) and derived cycle counts at the 10 MHz system clock
    // ****************************************************************
    localparam int ASRC_CLK_NS = 100;
    localparam int ASRC_ADDR_SETUP_NS = 0;
    localparam int ASRC_STROBE_WIDTH_NS = 10;
    localparam int ASRC_STROBE_TO_FLOAT_TIME_NS = 6;
    localparam int ASRC_WRITE_DATA_SETUP_TIME_NS = 7;
    localparam int ASRC_ACCESS_NS = 12;
    localparam int ASRC_FLOAT_NS = 6;

    // Least times round up, never below one cycle
    function automatic int asrc_cyc(input int ns);
        int c;
        c = (ns + ASRC_CLK_NS - 1) / ASRC_CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int ASRC_SETUP_CYC = asrc_cyc(ASRC_ADDR_SETUP_NS);
    localparam int ASRC_STROBE_CYC = asrc_cyc(ASRC_STROBE_WIDTH_NS);
    localparam int ASRC_WFLOAT_CYC =
        asrc_cyc(ASRC_STROBE_TO_FLOAT_TIME_NS + ASRC_WRITE_DATA_SETUP_TIME_NS);
    localparam int ASRC_READ_CYC = asrc_cyc(ASRC_ACCESS_NS);
    localparam int ASRC_TURN_CYC = asrc_cyc(ASRC_FLOAT_NS);
    localparam int ASRC_CW = 4;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic [ASRC_AW-1:0] addr;
        logic [ASRC_DW-1:0] wdata;
        logic write;
        logic low_byte_lane_n;
        logic high_byte_lane_n;
        logic oe_low_write;
    } asrc_req_t;

    typedef struct packed {
        logic chip_sel_n;
        logic out_en_n;
        logic write_strobe_n;
        logic low_byte_lane_n;
        logic high_byte_lane_n;
    } asrc_ctl_t;

    localparam asrc_ctl_t ASRC_CTL_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
endpackage

// File: asrc_lane_merge.sv
`timescale 1ns/1ps
module asrc_lane_merge
(
    input wire logic [asrc_pkg::ASRC_DW-1:0] i_bus,
    input wire logic i_low_n,
    input wire logic i_high_n,
    output logic [asrc_pkg::ASRC_DW-1:0] o_word
);
    import asrc_pkg::*;

    // Lanes not enabled float at the pins; return zero rather than noise
    always_comb
    begin
        o_word = '0;
        if (!i_low_n)
            o_word[ASRC_BW-1:0] = i_bus[ASRC_BW-1:0];
        if (!i_high_n)
            o_word[ASRC_DW-1:ASRC_BW] = i_bus[ASRC_DW-1:ASRC_BW];
    end
endmodule

// File: asrc_host.sv
`timescale 1ns/1ps
// Summary of operation
// - Host drives data for the cycle before the edge that ends the write and releases it on that edge.
// - Strobe write with output enable low lasts float time plus setup.
// - Host keeps strobe high throughout every read.
// - Address valid no later than select falling.
// - Host never drives data while the memory drives it.
module asrc_host
(
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_req_valid,
    input asrc_pkg::asrc_req_t i_req,
    output logic o_req_ready,
    output logic o_rd_valid,
    output logic [asrc_pkg::ASRC_DW-1:0] o_rd_data,
    output logic [asrc_pkg::ASRC_AW-1:0] o_mem_addr,
    output asrc_pkg::asrc_ctl_t o_mem_ctl,
    input wire logic [asrc_pkg::ASRC_DW-1:0] i_mem_dq,
    output logic [asrc_pkg::ASRC_DW-1:0] o_mem_dq,
    output logic [asrc_pkg::ASRC_DW-1:0] o_mem_dq_oe
);
    import asrc_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef enum logic [2:0] {ASRC_IDLE, ASRC_SETUP, ASRC_WSTROBE, ASRC_WEND,
                              ASRC_RDATA, ASRC_TURN} asrc_state_t;

    asrc_state_t state_q;
    asrc_req_t req_q;
    asrc_ctl_t ctl_q;
    logic [ASRC_CW-1:0] cnt_q;
    logic [ASRC_DW-1:0] dq_oe_q;
    logic [ASRC_DW-1:0] rd_word;

    // Byte-lane mask from the active-low lane enables
    function automatic logic [ASRC_DW-1:0] asrc_lane_mask(input logic low_n, input logic high_n);
        return {{ASRC_BW{~high_n}}, {ASRC_BW{~low_n}}};
    endfunction

    // Count load helper, clipped to counter width
    function automatic logic [ASRC_CW-1:0] asrc_load(input int cyc);
        return ASRC_CW'(cyc - 1);
    endfunction

    assign o_req_ready = (state_q == ASRC_IDLE);
    assign o_mem_ctl = ctl_q;
    assign o_mem_dq = req_q.wdata;
    assign o_mem_dq_oe = dq_oe_q;

    // ****************************************************************
    // Lane merge of the returned word
    // ****************************************************************
    asrc_lane_merge u_merge
    (
        .i_bus(i_mem_dq),
        .i_low_n(req_q.low_byte_lane_n),
        .i_high_n(req_q.high_byte_lane_n),
        .o_word(rd_word)
    );

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    // Request capture; address stays put for the whole access
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn)
        begin
            req_q <= '0;
            o_mem_addr <= '0;
        end
        else if (o_req_ready && i_req_valid)
        begin
            req_q <= i_req;
            o_mem_addr <= i_req.addr;
        end
    end

    // Control pins and state walk
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn)
        begin
            state_q <= ASRC_IDLE;
            ctl_q <= ASRC_CTL_IDLE;
            cnt_q <= '0;
            dq_oe_q <= '0;
        end
        else
        begin
            unique case (state_q)
                ASRC_IDLE:
                begin
                    dq_oe_q <= '0;
                    if (i_req_valid)
                    begin
                        // Select falls a cycle after address is set
                        state_q <= ASRC_SETUP;
                        cnt_q <= asrc_load(ASRC_SETUP_CYC);
                    end
                end
                ASRC_SETUP:
                begin
                    if (cnt_q != '0)
                        cnt_q <= cnt_q - 1'b1;
                    else if (req_q.write)
                    begin
                        ctl_q.chip_sel_n <= 1'b0;
                        ctl_q.out_en_n <= ~req_q.oe_low_write;
                        ctl_q.write_strobe_n <= 1'b0;
                        ctl_q.low_byte_lane_n <= req_q.low_byte_lane_n;
                        ctl_q.high_byte_lane_n <= req_q.high_byte_lane_n;
                        // Drive only after strobe low has turned memory off
                        state_q <= ASRC_WSTROBE;
                        cnt_q <= req_q.oe_low_write ? asrc_load(ASRC_WFLOAT_CYC)
                                                    : asrc_load(ASRC_STROBE_CYC);
                    end
                    else
                    begin
                        ctl_q.chip_sel_n <= 1'b0;
                        ctl_q.out_en_n <= 1'b0;
                        ctl_q.write_strobe_n <= 1'b1;
                        ctl_q.low_byte_lane_n <= req_q.low_byte_lane_n;
                        ctl_q.high_byte_lane_n <= req_q.high_byte_lane_n;
                        state_q <= ASRC_RDATA;
                        cnt_q <= asrc_load(ASRC_READ_CYC);
                    end
                end
                ASRC_WSTROBE:
                begin
                    // Wait out the float time with pins released, so no contention
                    if (cnt_q != '0)
                        cnt_q <= cnt_q - 1'b1;
                    else
                    begin
                        // Data driven one cycle into the strobe, memory already floating
                        dq_oe_q <= asrc_lane_mask(req_q.low_byte_lane_n, req_q.high_byte_lane_n);
                        state_q <= ASRC_WEND;
                    end
                end
                ASRC_WEND:
                begin
                    // Strobe and select rise together with a full cycle of data setup
                    ctl_q <= ASRC_CTL_IDLE;
                    // Pins released on the ending edge; zero hold is the least allowed
                    dq_oe_q <= '0;
                    state_q <= ASRC_IDLE;
                end
                ASRC_RDATA:
                begin
                    if (cnt_q != '0)
                        cnt_q <= cnt_q - 1'b1;
                    else
                    begin
                        ctl_q <= ASRC_CTL_IDLE;
                        state_q <= ASRC_TURN;
                        cnt_q <= asrc_load(ASRC_TURN_CYC);
                    end
                end
                ASRC_TURN:
                begin
                    // Bus turnaround: memory needs time to float before next write
                    if (cnt_q != '0)
                        cnt_q <= cnt_q - 1'b1;
                    else
                        state_q <= ASRC_IDLE;
                end
            endcase
        end
    end

    // Read return: sampled in the last cycle of the access
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn)
        begin
            o_rd_valid <= 1'b0;
            o_rd_data <= '0;
        end
        else
        begin
            o_rd_valid <= (state_q == ASRC_RDATA) && (cnt_q == '0);
            if ((state_q == ASRC_RDATA) && (cnt_q == '0))
                o_rd_data <= rd_word;
        end
    end
endmodule

// File: asrc_host_asserts.sv
`timescale 1ns/1ps
module asrc_host_asserts
(
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_req_valid,
    input asrc_pkg::asrc_req_t i_req,
    input wire logic o_req_ready,
    input wire logic o_rd_valid,
    input wire logic [asrc_pkg::ASRC_AW-1:0] o_mem_addr,
    input asrc_pkg::asrc_ctl_t o_mem_ctl,
    input wire logic [asrc_pkg::ASRC_DW-1:0] o_mem_dq_oe
);
    import asrc_pkg::*;
    // ****************
    // Pin sequencing
    // ****************
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);
    // Active-high views of select, write strobe, data drive and any lane enable
    wire logic cs = !o_mem_ctl.chip_sel_n;
    wire logic we = !o_mem_ctl.write_strobe_n;
    wire logic dq = |o_mem_dq_oe;
    wire logic lanes = !(o_mem_ctl.low_byte_lane_n && o_mem_ctl.high_byte_lane_n);
    sequence s_rd; $rose(cs) && !we; endsequence
    sequence s_wr; $rose(cs) && we; endsequence
    a_read_strobe_high: assert property (s_rd |-> !we [*2] ##1 !cs)
        else $error("strobe low in read");
    a_write_joint_end: assert property (s_wr |-> (cs && we) [*2] ##1 !(cs || we))
        else $error("write end not joint");
    a_data_before_end: assert property ((s_wr and lanes) |=> dq ##1 !we)
        else $error("write data late");
    a_drive_in_window: assert property (dq |-> cs && we)
        else $error("data driven outside write");
    a_addr_held: assert property (cs |-> $stable(o_mem_addr))
        else $error("address moved");
    a_lane_drive_match: assert property (dq |-> o_mem_dq_oe ==
        {{8{!o_mem_ctl.high_byte_lane_n}}, {8{!o_mem_ctl.low_byte_lane_n}}}) else $error("wrong lanes");
    a_read_answer: assert property (s_rd |-> ##1 o_rd_valid ##1 !o_rd_valid)
        else $error("read answer late");
    a_write_busy: assert property (i_req_valid && o_req_ready && i_req.write |=> !o_req_ready [*3] ##1 o_req_ready)
        else $error("write length");
endmodule
bind asrc_host asrc_host_asserts i_chk (.i_clk_sys, .i_rstn, .i_req_valid, .i_req, .o_req_ready, .o_rd_valid,
    .o_mem_addr, .o_mem_ctl, .o_mem_dq_oe);

// File: asrc_mem_model.sv
`timescale 1ns/1ps
module asrc_mem_model
(
    input wire logic [17:0] i_addr,
    input asrc_pkg::asrc_ctl_t i_ctl,
    input wire logic [15:0] i_dq,
    output logic [15:0] o_dq
);
    import asrc_pkg::*;
    logic [15:0] mem [logic [17:0]];
    logic [17:0] k_a;
    logic [15:0] k_d, cur, word;
    logic k_lo, k_hi, lo, hi;
    logic open = 1'h0;
    int upd = 0;
    // Hold the window, commit once select or strobe rises
    always @(i_ctl, i_dq, i_addr)
    begin
        if (!i_ctl.chip_sel_n && !i_ctl.write_strobe_n)
        begin
            {open, k_a, k_d} = {1'h1, i_addr, i_dq};
            {k_lo, k_hi} = {!i_ctl.low_byte_lane_n, !i_ctl.high_byte_lane_n};
        end
        else if (open)
        begin
            cur = mem.exists(k_a) ? mem[k_a] : 16'h0000;
            mem[k_a] = {k_hi ? k_d[15:8] : cur[15:8], k_lo ? k_d[7:0] : cur[7:0]};
            open = 1'h0;
            upd++;
        end
    end
    // Float shows the inverse, so a stale word never reads right
    always @(i_ctl, i_addr, upd)
    begin
        lo = !i_ctl.chip_sel_n && !i_ctl.out_en_n && i_ctl.write_strobe_n;
        hi = lo && !i_ctl.high_byte_lane_n;
        lo = lo && !i_ctl.low_byte_lane_n;
        word = mem.exists(i_addr) ? mem[i_addr] : 16'h0000;
        o_dq = {hi ? word[15:8] : ~word[15:8], lo ? word[7:0] : ~word[7:0]};
    end
endmodule

// File: async_sram_word_port_tb.sv
`timescale 1ns/1ps
module async_sram_word_port_tb;
    import asrc_pkg::*;
    logic i_clk_sys, i_rstn, i_req_valid, o_req_ready, o_rd_valid;
    asrc_req_t i_req;
    asrc_ctl_t o_mem_ctl;
    logic [15:0] o_rd_data, o_mem_dq, o_mem_dq_oe, mem_dq, bus;
    logic [17:0] o_mem_addr;
    int miscompares = 0;
    int n_compared = 0;
    int cycles = 0;
    // Pin level; the delay gives the data a hold past the closing edge
    assign #1 bus = (o_mem_dq & o_mem_dq_oe) | (mem_dq & ~o_mem_dq_oe);
    asrc_host i_dut (.i_clk_sys, .i_rstn, .i_req_valid, .i_req, .o_req_ready, .o_rd_valid, .o_rd_data,
        .o_mem_addr, .o_mem_ctl, .i_mem_dq(bus), .o_mem_dq, .o_mem_dq_oe);
    asrc_mem_model i_mem (.i_addr(o_mem_addr), .i_ctl(o_mem_ctl), .i_dq(bus), .o_dq(mem_dq));
    // Clock
    initial
    begin
        i_clk_sys = 1'h0;
        forever #50 i_clk_sys = ~i_clk_sys;
    end
    // Hang guard, far above the run's length
    always @(posedge i_clk_sys)
    begin
        cycles++;
        if (cycles == 1000)
        begin
            miscompares++;
            complete_run();
        end
    end
    task automatic chk(input string nm, input logic [31:0] exp, got);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask
    task automatic complete_run();
        if (miscompares == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic access(input logic w, ln, hn, oew, input logic [17:0] a, input logic [15:0] d,
        output logic [15:0] rd);
        int n;
        n = 0;
        while (o_req_ready !== 1'h1 && n < 20)
        begin
            @(posedge i_clk_sys) #1;
            n++;
        end
        i_req_valid = 1'h1;
        i_req = '{a, d, w, ln, hn, oew};
        @(posedge i_clk_sys) #1;
        i_req_valid = 1'h0;
        while (!w && o_rd_valid !== 1'h1 && n < 20)
        begin
            @(posedge i_clk_sys) #1;
            n++;
        end
        rd = o_rd_data;
        chk("handshake timeout", 32'h0, n / 20);
    endtask
    task automatic wr(input logic ln, hn, oew, input logic [17:0] a, input logic [15:0] d);
        logic [15:0] rd;
        access(1'h1, ln, hn, oew, a, d, rd);
    endtask
    task automatic rdx(input logic ln, hn, input logic [17:0] a, input logic [15:0] exp);
        logic [15:0] rd;
        access(1'h0, ln, hn, 1'h0, a, 16'h0000, rd);
        chk("read data", {16'h0000, exp}, {16'h0000, rd});
    endtask
    task automatic t_reset();
        @(posedge i_clk_sys) #1;
        chk("idle pins", 32'h1, {31'h0, {o_mem_ctl, o_mem_dq_oe, o_req_ready, o_rd_valid} ===
            {ASRC_CTL_IDLE, 16'h0000, 2'h2}});
    endtask
    task automatic t_full();
        wr(1'h0, 1'h0, 1'h0, 18'h3FFFF, 16'hA55A);
        wr(1'h0, 1'h0, 1'h1, 18'h00000, 16'h1234);
        rdx(1'h0, 1'h0, 18'h3FFFF, 16'hA55A);
        rdx(1'h0, 1'h0, 18'h00000, 16'h1234);
    endtask
    task automatic t_lanes();
        wr(1'h0, 1'h1, 1'h0, 18'h3FFFF, 16'hBEC3);
        wr(1'h1, 1'h0, 1'h1, 18'h00000, 16'h7E00);
        rdx(1'h0, 1'h0, 18'h3FFFF, 16'hA5C3);
        rdx(1'h0, 1'h1, 18'h3FFFF, 16'h00C3);
        rdx(1'h1, 1'h0, 18'h00000, 16'h7E00);
    endtask
    task automatic t_none();
        wr(1'h1, 1'h1, 1'h0, 18'h00000, 16'hFFFF);
        rdx(1'h1, 1'h1, 18'h00000, 16'h0000);
        rdx(1'h0, 1'h0, 18'h00000, 16'h7E34);
    endtask
    initial
    begin
        i_rstn = 1'h0;
        i_req_valid = 1'h0;
        i_req = '0;
        repeat (20) @(posedge i_clk_sys);
        #1 i_rstn = 1'h1;
        t_reset();
        t_full();
        t_lanes();
        t_none();
        complete_run();
    end
endmodule
